// ---- hw/acs_defines.svh ----
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ACS_OFF_SETUP_ZERO   12'h000
`define ACS_OFF_SETUP_ONE    12'h004
`define ACS_OFF_SETUP_TWO    12'h008
`define ACS_OFF_REF_CTRL     12'h00C
`define ACS_OFF_RESULT       12'h010
`define ACS_OFF_STATUS       12'h014

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACS_Z_ENABLE_BIT     0
`define ACS_Z_GO_BIT         1
`define ACS_Z_CHAN_LSB       2
`define ACS_O_FMT_BIT        7
`define ACS_O_CLK_LSB        4
`define ACS_O_NREF_BIT       2
`define ACS_O_PREF_LSB       0
`define ACS_R_EN_BIT         7
`define ACS_R_RDY_BIT        6
`define ACS_R_BUF_LSB        0
`define ACS_S_FLAG_BIT       0
`define ACS_S_IE_BIT         1

// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define ACS_RST_SETUP_ZERO   8'h00
`define ACS_RST_SETUP_ONE    8'h00
`define ACS_RST_SETUP_TWO    8'h0F
`define ACS_RST_REF_CTRL     8'h00
`define ACS_MASK_SETUP_ONE   8'hF7
`define ACS_MASK_REF_CTRL    8'hBF
`define ACS_NEG_SINGLE       4'hF
`define ACS_PREF_RESERVED    2'h2
`define ACS_MAX_CHANNEL      5'h11

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ACS_CLK_MHZ          20
`define ACS_BIT_PERIODS      15
`define ACS_RESULT_BITS      12
`define ACS_BUF_SETTLE_US    30
`define ACS_BUF_SETTLE_CYC   (`ACS_BUF_SETTLE_US * `ACS_CLK_MHZ)
`define ACS_REF_SETTLE_CYC   64

`endif

// ---- hw/acs_pkg.sv ----
package acs_pkg;

  // Conversion clock source codes
  typedef enum logic [2:0] {
    ACS_CLK_DIV2  = 3'h0,
    ACS_CLK_DIV8  = 3'h1,
    ACS_CLK_DIV32 = 3'h2,
    ACS_CLK_RC_A  = 3'h3,
    ACS_CLK_DIV4  = 3'h4,
    ACS_CLK_DIV16 = 3'h5,
    ACS_CLK_DIV64 = 3'h6,
    ACS_CLK_RC_B  = 3'h7
  } acs_clk_sel_e;

  // Converter state
  typedef enum logic [2:0] {
    ACS_IDLE    = 3'b001,
    ACS_CONVERT = 3'b010,
    ACS_FINISH  = 3'b100
  } acs_state_e;

  // Analog routing presented to the converter core
  typedef struct packed {
    logic [4:0] pos_channel;
    logic [3:0] neg_channel;
    logic       single_ended;
    logic       neg_ref_pin;
    logic [1:0] pos_ref;
  } acs_route_s;

  // Sample handed over from the core
  typedef struct packed {
    logic        sign;
    logic [11:0] magnitude;
  } acs_sample_s;

endpackage

// ---- hw/acs_tick_gen.sv ----
`timescale 1ns/1ns
`include "acs_defines.svh"
// Bit-period tick from system clock divider or synchronised RC clock
module acs_tick_gen
  import acs_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire acs_clk_sel_e clk_sel,
  input  wire logic         rc_clk,
  input  wire logic         run,
  output logic              tick
);

  logic [5:0] div_cnt;
  logic [5:0] div_last;
  logic       rc_meta;
  logic       rc_sync;
  logic       rc_prev;
  logic       rc_mode;

  // Divider terminal count per selection
  always_comb begin
    rc_mode = 1'b0;
    case (clk_sel)
      ACS_CLK_DIV2:  div_last = 6'd1;
      ACS_CLK_DIV4:  div_last = 6'd3;
      ACS_CLK_DIV8:  div_last = 6'd7;
      ACS_CLK_DIV16: div_last = 6'd15;
      ACS_CLK_DIV32: div_last = 6'd31;
      ACS_CLK_DIV64: div_last = 6'd63;
      default: begin
        div_last = 6'd0;
        rc_mode  = 1'b1;
      end
    endcase
  end

  // System clock divider
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 6'd0;
    end else if (!run || div_cnt == div_last) begin
      div_cnt <= 6'd0;
    end else begin
      div_cnt <= div_cnt + 6'd1;
    end
  end

  // RC clock synchroniser and edge history
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      rc_meta <= rc_clk;
      rc_sync <= rc_meta;
      rc_prev <= rc_sync;
    end
  end

  assign tick = run && (rc_mode ? (rc_sync && !rc_prev) : (div_cnt == div_last));

endmodule

// ---- hw/acs_settle_timer.sv ----
`timescale 1ns/1ns
// Counts cycles while enabled and reports done once the count expires
module acs_settle_timer #(
  parameter int unsigned CYCLES = 600
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic restart,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] count;

  // Count up while enabled, restart on request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (!enable || restart) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + CW'(1);
    end
  end

  assign done = enable && !restart && (count == LAST);

endmodule

// ---- hw/acs_converter_ctrl.sv ----
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_converter_ctrl
  import acs_pkg::*;
#(
  parameter int unsigned REF_SETTLE = `ACS_REF_SETTLE_CYC,
  parameter int unsigned BUF_SETTLE = `ACS_BUF_SETTLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Converter core
  input  wire logic        rc_clk,
  input  wire logic        cmp_in,
  input  wire acs_sample_s sample,
  output acs_route_s       route,
  output logic             core_enable,
  output logic             sample_hold,
  output logic [3:0]       bit_index,
  output logic             buffer_ready,
  output logic             conv_irq
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0]  setup_zero;
  logic [7:0]  setup_one;
  logic [7:0]  setup_two;
  logic [7:0]  reference_control;
  logic [15:0] result;
  logic        int_flag;
  logic        int_enable;
  logic        go_done;
  acs_state_e  state;
  logic [3:0]  period_cnt;
  logic [11:0] sar_bits;
  logic        tick;
  logic        ref_settled;
  logic        buf_settled;
  logic        finish;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [15:0] next_result;
  logic [12:0] twos;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign finish  = (state == ACS_CONVERT) && tick
                   && (period_cnt == 4'(`ACS_BIT_PERIODS - 1));

  // Address decode
  always_comb begin
    if (paddr == `ACS_OFF_SETUP_ZERO) begin
      addr_ok = 1'b1;
    end else if (paddr == `ACS_OFF_SETUP_ONE) begin
      addr_ok = 1'b1;
    end else if (paddr == `ACS_OFF_SETUP_TWO) begin
      addr_ok = 1'b1;
    end else if (paddr == `ACS_OFF_REF_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == `ACS_OFF_RESULT) begin
      addr_ok = 1'b1;
    end else if (paddr == `ACS_OFF_STATUS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_zero        <= `ACS_RST_SETUP_ZERO;
      setup_one         <= `ACS_RST_SETUP_ONE;
      setup_two         <= `ACS_RST_SETUP_TWO;
      reference_control <= `ACS_RST_REF_CTRL;
      int_enable        <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `ACS_OFF_SETUP_ZERO) begin
        setup_zero <= pwdata[7:0];
      end else if (paddr == `ACS_OFF_SETUP_ONE) begin
        setup_one <= pwdata[7:0] & `ACS_MASK_SETUP_ONE;
      end else if (paddr == `ACS_OFF_SETUP_TWO) begin
        setup_two <= {4'h0, pwdata[3:0]};
      end else if (paddr == `ACS_OFF_REF_CTRL) begin
        reference_control <= pwdata[7:0] & `ACS_MASK_REF_CTRL;
      end else if (paddr == `ACS_OFF_STATUS) begin
        int_enable <= pwdata[`ACS_S_IE_BIT];
      end
    end
  end

  // Go/done flag: set by software, cleared by hardware on completion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      go_done <= 1'b0;
    end else if (finish) begin
      go_done <= 1'b0;
    end else if (wr_en && paddr == `ACS_OFF_SETUP_ZERO) begin
      // Enable and go written together must start; enable low drops go
      go_done <= pwdata[`ACS_Z_ENABLE_BIT] && pwdata[`ACS_Z_GO_BIT];
    end else if (!setup_zero[`ACS_Z_ENABLE_BIT]) begin
      go_done <= 1'b0;
    end
  end

  // Interrupt flag: completion wins over a software clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_flag <= 1'b0;
    end else if (finish) begin
      int_flag <= 1'b1;
    end else if (wr_en && paddr == `ACS_OFF_STATUS && pwdata[`ACS_S_FLAG_BIT]) begin
      int_flag <= 1'b0;
    end
  end

  assign conv_irq = int_flag && int_enable;

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  acs_tick_gen u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_sel (acs_clk_sel_e'(setup_one[`ACS_O_CLK_LSB +: 3])),
    .rc_clk  (rc_clk),
    .run     (state == ACS_CONVERT),
    .tick    (tick)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ACS_IDLE;
      period_cnt <= 4'h0;
    end else begin
      case (state)
        ACS_IDLE: begin
          period_cnt <= 4'h0;
          if (go_done) begin
            state <= ACS_CONVERT;
          end
        end
        ACS_CONVERT: begin
          if (!go_done) begin
            state <= ACS_IDLE;
          end else if (finish) begin
            state <= ACS_FINISH;
          end else if (tick) begin
            period_cnt <= period_cnt + 4'h1;
          end
        end
        ACS_FINISH: begin
          state <= ACS_IDLE;
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // Successive approximation: periods 1..12 resolve bits MSB first
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sar_bits <= 12'h000;
    end else if (state == ACS_IDLE) begin
      sar_bits <= 12'h000;
    end else if (tick && period_cnt >= 4'h1 && period_cnt <= 4'(`ACS_RESULT_BITS)) begin
      sar_bits[4'(`ACS_RESULT_BITS) - period_cnt] <= cmp_in;
    end
  end

  assign core_enable = setup_zero[`ACS_Z_ENABLE_BIT];
  assign sample_hold = (state == ACS_CONVERT) && (period_cnt == 4'h0)
                       && go_done && setup_zero[`ACS_Z_ENABLE_BIT];
  assign bit_index   = (period_cnt >= 4'h1 && period_cnt <= 4'(`ACS_RESULT_BITS))
                       ? 4'(`ACS_RESULT_BITS) - period_cnt : 4'h0;

  // Result formatting
  always_comb begin
    twos = sample.sign ? (13'h0000 - {1'b0, sample.magnitude}) : {1'b0, sample.magnitude};
    if (setup_one[`ACS_O_FMT_BIT]) begin
      next_result = {{3{twos[12]}}, twos};
    end else begin
      next_result = {sample.sign, 3'h0, sample.magnitude};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 16'h0000;
    end else if (finish) begin
      result <= next_result;
    end
  end

  // ---------------------------------------------------------------
  // Analog routing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      route <= '0;
    end else begin
      route.pos_channel  <= (setup_zero[`ACS_Z_CHAN_LSB +: 5] > `ACS_MAX_CHANNEL)
                            ? 5'h00 : setup_zero[`ACS_Z_CHAN_LSB +: 5];
      route.neg_channel  <= setup_two[3:0];
      route.single_ended <= (setup_two[3:0] == `ACS_NEG_SINGLE);
      route.neg_ref_pin  <= setup_one[`ACS_O_NREF_BIT];
      route.pos_ref      <= (setup_one[`ACS_O_PREF_LSB +: 2] == `ACS_PREF_RESERVED)
                            ? 2'h0 : setup_one[`ACS_O_PREF_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Fixed reference readiness
  // ---------------------------------------------------------------
  acs_settle_timer #(
    .CYCLES (REF_SETTLE)
  ) u_ref_settle (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .enable  (reference_control[`ACS_R_EN_BIT]),
    .restart (1'b0),
    .done    (ref_settled)
  );

  acs_settle_timer #(
    .CYCLES (BUF_SETTLE)
  ) u_buf_settle (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .enable  (reference_control[`ACS_R_EN_BIT] && reference_control[1:0] != 2'h0),
    .restart (wr_en && paddr == `ACS_OFF_REF_CTRL),
    .done    (buf_settled)
  );

  assign buffer_ready = ref_settled && buf_settled;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == `ACS_OFF_SETUP_ZERO) begin
        prdata <= {24'h00_0000, setup_zero[7:2], go_done, setup_zero[0]};
      end else if (paddr == `ACS_OFF_SETUP_ONE) begin
        prdata <= {24'h00_0000, setup_one};
      end else if (paddr == `ACS_OFF_SETUP_TWO) begin
        prdata <= {24'h00_0000, setup_two};
      end else if (paddr == `ACS_OFF_REF_CTRL) begin
        prdata <= {24'h00_0000, reference_control[7], ref_settled,
                   reference_control[5:0]};
      end else if (paddr == `ACS_OFF_RESULT) begin
        prdata <= {16'h0000, result};
      end else if (paddr == `ACS_OFF_STATUS) begin
        prdata <= {30'h0000_0000, int_enable, int_flag};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ---- dv/acs_converter_ctrl_properties.sv ----
`timescale 1ns/1ns
// Port-level checks of the converter control block
module acs_converter_ctrl_chk
  import acs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rc_clk,
  input wire logic        cmp_in,
  input wire acs_sample_s sample,
  input wire acs_route_s  route,
  input wire logic        core_enable,
  input wire logic        sample_hold,
  input wire logic [3:0]  bit_index,
  input wire logic        buffer_ready,
  input wire logic        conv_irq
);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic wr;
  // Write accepted in the access phase
  assign wr = psel && penable && pwrite;
  a_single_mode: assert property (route.single_ended == (route.neg_channel == 4'hF))
    else $error("single-ended flag disagrees with negative channel");
  a_chan_limit: assert property (route.pos_channel <= 5'h11)
    else $error("positive channel beyond the last source");
  a_pref_reserved: assert property (route.pos_ref != 2'h2)
    else $error("reserved positive reference code routed");
  a_nref_follow: assert property (wr && paddr == 12'h004 |=> ##1
    route.neg_ref_pin == $past(pwdata[2], 2)) else $error("negative reference not routed");
  a_pref_follow: assert property (wr && paddr == 12'h004 && pwdata[1:0] != 2'h2 |=> ##1
    route.pos_ref == $past(pwdata[1:0], 2)) else $error("positive reference not routed");
  a_neg_follow: assert property (wr && paddr == 12'h008 |=> ##1
    route.neg_channel == $past(pwdata[3:0], 2)) else $error("negative channel not routed");
  a_pos_follow: assert property (wr && paddr == 12'h000 && pwdata[6:2] <= 5'h11 |=> ##1
    route.pos_channel == $past(pwdata[6:2], 2)) else $error("positive channel not routed");
  a_enable_follow: assert property (wr && paddr == 12'h000 |=>
    core_enable == $past(pwdata[0])) else $error("converter enable not taken");
  a_hold_enabled: assert property (sample_hold |-> core_enable)
    else $error("conversion running while disabled");
  a_irq_masked: assert property (wr && paddr == 12'h014 && !pwdata[1] |=> !conv_irq)
    else $error("interrupt raised while masked");
endmodule

bind acs_converter_ctrl acs_converter_ctrl_chk i_chk (
  .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .pslverr, .rc_clk, .cmp_in, .sample, .route, .core_enable, .sample_hold,
  .bit_index, .buffer_ready, .conv_irq
);

// ---- dv/acs_converter_ctrl_bench.sv ----
`timescale 1ns/1ns
// Self-checking bench of the converter control block
module acs_converter_ctrl_bench;
  import acs_pkg::*;
  localparam logic [11:0] r0 = 12'h000;
  localparam logic [11:0] r1 = 12'h004;
  localparam logic [11:0] r2 = 12'h008;
  localparam logic [11:0] rf = 12'h00C;
  localparam logic [11:0] rr = 12'h010;
  localparam logic [11:0] rs = 12'h014;
  logic        sys_clk, rst_b, psel, penable, pwrite, rc_clk, cmp_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, core_enable, sample_hold, buffer_ready, conv_irq, err;
  logic [3:0]  bit_index;
  acs_sample_s sample;
  acs_route_s  route;
  int          error_cnt, n_tests, cyc, rc_cnt;
  int          dv [8] = '{2, 8, 32, 6, 4, 16, 64, 6};

  // Short settle counts keep the run brief
  acs_converter_ctrl #(.REF_SETTLE(4), .BUF_SETTLE(4)) i_dut (
    .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .rc_clk, .cmp_in, .sample, .route, .core_enable, .sample_hold,
    .bit_index, .buffer_ready, .conv_irq
  );

  // System clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // RC oscillator at six system clocks, comparator pattern, hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
    if (rc_cnt == 2) rc_clk <= ~rc_clk;
    cmp_in <= cyc[0];
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    check(rd[15:0], e);
    check(rd[31:16], 16'h0000);
  endtask

  task print_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    rdc(r0, 16'h0000);
    rdc(r1, 16'h0000);
    rdc(r2, 16'h000F);
    rdc(rf, 16'h0000);
    rdc(rr, 16'h0000);
    rdc(rs, 16'h0000);
  endtask

  task automatic t_route;
    apb(1'b1, r1, 16'h00FF);
    rdc(r1, 16'h00F7);
    check(16'(route.neg_ref_pin), 16'h0001);
    check(16'(route.pos_ref), 16'h0003);
    apb(1'b1, r1, 16'h0002);
    @(posedge sys_clk);
    check(16'(route.pos_ref), 16'h0000);
    check(16'(route.neg_ref_pin), 16'h0000);
    apb(1'b1, r2, 16'h0005);
    @(posedge sys_clk);
    check(16'({route.neg_channel, route.single_ended}), 16'h000A);
    apb(1'b1, r2, 16'h000F);
    @(posedge sys_clk);
    check(16'(route.single_ended), 16'h0001);
    apb(1'b1, r0, 16'h0044);
    @(posedge sys_clk);
    check(16'(route.pos_channel), 16'h0011);
    apb(1'b1, r0, 16'h0048);
    @(posedge sys_clk);
    check(16'(route.pos_channel), 16'h0000);
  endtask

  // Unmapped read returns zero with an error response
  task automatic t_unmapped;
    apb(1'b0, 12'h018, 16'h0000);
    check(rd[15:0], 16'h0000);
    check(16'(err), 16'h0001);
  endtask

  // Start request while disabled is dropped
  task automatic t_go_off;
    apb(1'b1, r0, 16'h0002);
    rdc(r0, 16'h0000);
    check(16'(sample_hold), 16'h0000);
  endtask

  // Polled conversion with the interrupt masked
  task automatic t_irq;
    int n;
    apb(1'b1, rs, 16'h0000);
    apb(1'b1, r1, 16'h0000);
    apb(1'b1, r0, 16'h0003);
    n = 0;
    do begin
      apb(1'b0, r0, 16'h0000);
      n++;
    end while (rd[1] !== 1'b0 && n < 40);
    check(16'(n < 40), 16'h0001);
    check(16'(conv_irq), 16'h0000);
    rdc(rs, 16'h0001);
    apb(1'b1, rs, 16'h0002);
    check(16'(conv_irq), 16'h0001);
    apb(1'b1, rs, 16'h0003);
    check(16'(conv_irq), 16'h0000);
  endtask

  // Every clock code, both result formats, interrupt completion
  task automatic t_convert;
    int n;
    logic [11:0] m;
    logic [15:0] e;
    apb(1'b1, rs, 16'h0002);
    for (int c = 0; c < 8; c++) begin
      m = 12'h120 + 12'(c);
      e = c[0] ? 16'h0000 - {4'h0, m} : {4'h8, m};
      sample <= {1'b1, m};
      apb(1'b1, r1, {8'h00, c[0], 3'(c), 4'h0});
      repeat (4) @(posedge sys_clk);
      apb(1'b1, r0, 16'h0003);
      n = 0;
      while (conv_irq !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        n++;
      end
      // The free-running RC clock may tick almost at once, so its first period is partial
      check(16'(n >= ((c % 4 == 3) ? 14 * dv[c] : 15 * dv[c]) && n <= 16 * dv[c] + 8), 16'h0001);
      rdc(r0, 16'h0001);
      rdc(rr, e);
      apb(1'b1, rs, 16'h0003);
      check(16'(conv_irq), 16'h0000);
    end
  endtask

  // Reference enable, settle, ready flag and drop
  task automatic t_ref;
    int n;
    apb(1'b1, rf, 16'h0081);
    check(16'(buffer_ready), 16'h0000);
    n = 0;
    while (buffer_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(16'(n >= 2 && n < 40), 16'h0001);
    rdc(rf, 16'h00C1);
    apb(1'b1, rf, 16'h0001);
    @(posedge sys_clk);
    check(16'(buffer_ready), 16'h0000);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rc_clk = 1'b0;
    cmp_in = 1'b0;
    sample = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_route;
    t_unmapped;
    t_go_off;
    t_irq;
    t_convert;
    t_ref;
    print_verdict;
  end
endmodule
